/* File: dsau_top.sv */
// data space access unit: address generators, ram, sfr decode, dma ram
// Behaviour
// - memory is byte addressed, 16-bit words, low byte even, high odd.
// - post-increment steps pointer by one for bytes, two for words.
// - byte read fetches word, picks byte by bit zero, low lane.
// - shared word decode, separate byte write enables per lane.
// - odd word address is not done as word; raises address error.
// - misaligned read completes; misaligned write dropped; trap follows.
// - byte load into working register keeps its high byte.
// - sign-extend widens 8-bit to 16-bit; unsigned widen clears high byte.
// - special function registers occupy 0x0000 through 0x07FF.
// - unused special function register addresses read as zero.
// - 0x0000 to 0x1FFF is near space, 13-bit direct field.
// - whole space reachable by 16-bit direct or pointer indirect.
// - two independent address generators serve X and Y concurrently.
// - X has separate read and write buses; read bus covers all.
// - multiply-accumulate uses Y read path concurrently with X.
// - modulo in X and Y; bit-reversed only for X writes.
// - writes see combined X/Y range; fixed boundary.
// - effective addresses are 16-bit byte pointers, 64 Kbytes.
// - 1 Kbyte dual port region atop Y, CPU and DMA simultaneous.
// - same-location same-cycle writes: CPU wins, CPU never stalls.
// - addresses outside implemented memory read as zero.
// - top address bit set maps no RAM; reserved for program window.
`timescale 1ns/1ns
`default_nettype none
module dsau_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // x read generator
  input wire logic xr_req_i,
  input wire logic xr_byte_i,
  input wire dsau_pkg::dsau_amode_t xr_mode_i,
  input wire logic [15:0] xr_lit_i,
  input wire logic [15:0] xr_ptr_i,
  output logic [15:0] xr_ptr_nxt_o,
  output logic [15:0] xr_rdata_o,
  output logic xr_valid_o,
  // y read generator, word reads for multiply-accumulate
  input wire logic yr_req_i,
  input wire logic yr_postinc_i,
  input wire logic [15:0] yr_ptr_i,
  output logic [15:0] yr_ptr_nxt_o,
  output logic [15:0] yr_rdata_o,
  output logic yr_valid_o,
  // modulo windows
  input wire logic xmod_en_i,
  input wire logic [15:0] xmod_start_i,
  input wire logic [15:0] xmod_end_i,
  input wire logic ymod_en_i,
  input wire logic [15:0] ymod_start_i,
  input wire logic [15:0] ymod_end_i,
  // x write generator
  input wire logic xw_req_i,
  input wire logic xw_byte_i,
  input wire dsau_pkg::dsau_amode_t xw_mode_i,
  input wire logic [15:0] xw_lit_i,
  input wire logic [15:0] xw_ptr_i,
  input wire logic [15:0] xw_wdata_i,
  input wire logic xw_bitrev_en_i,
  input wire logic [15:0] xw_brmod_i,
  output logic [15:0] xw_ptr_nxt_o,
  // special function register bus
  output logic [15:0] sfr_addr_o,
  output logic sfr_rd_o,
  input wire logic sfr_hit_i,
  input wire logic [15:0] sfr_rdata_i,
  output logic [15:0] sfr_waddr_o,
  output logic [1:0] sfr_wbe_o,
  output logic [15:0] sfr_wdata_o,
  // dma controller
  input wire logic dma_req_i,
  input wire logic dma_we_i,
  input wire logic [dsau_pkg::DMA_IW-1:0] dma_idx_i,
  input wire logic [15:0] dma_wdata_i,
  output logic [15:0] dma_rdata_o,
  output logic dma_valid_o,
  output logic dma_lost_o,
  // working register load and extend
  input wire dsau_pkg::dsau_wop_t wop_i,
  input wire logic [15:0] wop_reg_i,
  input wire logic [15:0] wop_data_i,
  output logic [15:0] wop_res_o,
  output logic wop_done_o,
  // trap
  output logic addr_err_o,
  output logic addr_err_wr_o
);
  import dsau_pkg::*;

  function automatic logic [15:0] ea_of(dsau_amode_t m, logic [15:0] lit,
                                        logic [15:0] ptr);
    logic [15:0] ea;
    ea = ptr;
    unique case (m)
      AM_NEAR: ea = {3'h0, lit[NEAR_W-1:0]};
      AM_DIR16: ea = lit;
      AM_IND: ea = ptr;
      AM_IND_PI: ea = ptr;
    endcase
    return ea;
  endfunction

  function automatic logic [15:0] rev16(logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

  function automatic logic [15:0] ptr_step(logic [15:0] p, logic byte_op,
                                           logic men, logic [15:0] ms,
                                           logic [15:0] me);
    logic [15:0] n;
    n = p + (byte_op ? STEP_BYTE : STEP_WORD);
    if (men && (p <= me) && (n > me)) begin
      n = ms;
    end
    return n;
  endfunction

  function automatic logic in_sfr(logic [15:0] a);
    return a <= SFR_HI;
  endfunction

  // top bit set is never ram
  function automatic logic in_gen(logic [15:0] a);
    return !a[WIN_BIT] && (a >= RAM_LO) && (a < DMA_LO);
  endfunction

  function automatic logic in_dma(logic [15:0] a);
    return !a[WIN_BIT] && (a >= DMA_LO) && (a <= DMA_HI);
  endfunction

  function automatic logic [GEN_IW-1:0] gen_idx(logic [15:0] a);
    logic [15:0] off;
    off = a - RAM_LO;
    return off[GEN_IW:1];
  endfunction

  function automatic logic [DMA_IW-1:0] dma_idx(logic [15:0] a);
    logic [15:0] off;
    off = a - DMA_LO;
    return off[DMA_IW:1];
  endfunction

  function automatic logic [15:0] lane_sel(logic [15:0] w, logic byte_op,
                                           logic a0);
    if (!byte_op) begin
      return w;
    end
    return {8'h00, a0 ? w[15:8] : w[7:0]};
  endfunction

  logic [15:0] gen_mem_r [GEN_WORDS];
  logic [15:0] xr_ea;
  logic [15:0] yr_ea;
  logic [15:0] xw_ea;
  logic xr_mis;
  logic yr_mis;
  logic xw_mis;
  logic [15:0] xr_word;
  logic [15:0] yr_word;
  logic [15:0] dx_word;
  logic [15:0] dy_word;
  logic [1:0] xw_be;
  logic [15:0] xw_lanes;
  logic xw_go;
  logic dma_cpu_we;

  assign xr_ea = ea_of(xr_mode_i, xr_lit_i, xr_ptr_i);
  assign xw_ea = ea_of(xw_mode_i, xw_lit_i, xw_ptr_i);
  assign yr_ea = yr_ptr_i;

  assign xr_mis = xr_req_i && !xr_byte_i && xr_ea[0];
  assign yr_mis = yr_req_i && yr_ea[0];
  assign xw_mis = xw_req_i && !xw_byte_i && xw_ea[0];

  always_comb begin
    xr_ptr_nxt_o = xr_ptr_i;
    if (xr_mode_i == AM_IND_PI) begin
      xr_ptr_nxt_o = ptr_step(xr_ptr_i, xr_byte_i, xmod_en_i, xmod_start_i,
                              xmod_end_i);
    end
  end

  always_comb begin
    yr_ptr_nxt_o = yr_ptr_i;
    if (yr_postinc_i) begin
      yr_ptr_nxt_o = ptr_step(yr_ptr_i, 1'b0, ymod_en_i, ymod_start_i,
                              ymod_end_i);
    end
  end

  // bit-reversed update on x writes only
  always_comb begin
    xw_ptr_nxt_o = xw_ptr_i;
    if (xw_mode_i == AM_IND_PI) begin
      if (xw_bitrev_en_i && !xw_byte_i) begin
        xw_ptr_nxt_o = rev16(rev16(xw_ptr_i) + rev16(xw_brmod_i));
      end else begin
        xw_ptr_nxt_o = ptr_step(xw_ptr_i, xw_byte_i, xmod_en_i,
                                xmod_start_i, xmod_end_i);
      end
    end
  end

  // even address is the low lane
  always_comb begin
    xw_be = BE_ALL;
    xw_lanes = xw_wdata_i;
    if (xw_byte_i) begin
      xw_be = xw_ea[0] ? BE_HI : BE_LO;
      xw_lanes = {xw_wdata_i[7:0], xw_wdata_i[7:0]};
    end
  end

  assign xw_go = xw_req_i && !xw_mis;
  // one write bus over combined space
  assign dma_cpu_we = xw_go && in_dma(xw_ea);

  always_ff @(posedge clk_i) begin
    if (xw_go && in_gen(xw_ea)) begin
      if (xw_be[0]) begin
        gen_mem_r[gen_idx(xw_ea)][7:0] <= xw_lanes[7:0];
      end
      if (xw_be[1]) begin
        gen_mem_r[gen_idx(xw_ea)][15:8] <= xw_lanes[15:8];
      end
    end
  end

  // sfr write is presented one cycle later from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sfr_waddr_o <= WORD_ZERO;
      sfr_wbe_o <= BE_NONE;
      sfr_wdata_o <= WORD_ZERO;
    end else begin
      sfr_wbe_o <= BE_NONE;
      if (xw_go && in_sfr(xw_ea)) begin
        sfr_waddr_o <= {xw_ea[15:1], 1'b0};
        sfr_wbe_o <= xw_be;
        sfr_wdata_o <= xw_lanes;
      end
    end
  end

  // the read phase of sfr access is combinational so that the
  // peripheral answer lands in the same edge as ram data
  assign sfr_addr_o = {xr_ea[15:1], 1'b0};
  assign sfr_rd_o = xr_req_i && in_sfr(xr_ea);

  // dual ported region at top of y
  dsau_dmaram u_dmaram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cpu_we_i(dma_cpu_we),
    .cpu_be_i(xw_be),
    .cpu_widx_i(dma_idx(xw_ea)),
    .cpu_wdata_i(xw_lanes),
    .xr_idx_i(dma_idx(xr_ea)),
    .yr_idx_i(dma_idx(yr_ea)),
    .xr_word_o(dx_word),
    .yr_word_o(dy_word),
    .dma_req_i(dma_req_i),
    .dma_we_i(dma_we_i),
    .dma_idx_i(dma_idx_i),
    .dma_wdata_i(dma_wdata_i),
    .dma_rdata_o(dma_rdata_o),
    .dma_valid_o(dma_valid_o),
    .dma_lost_o(dma_lost_o)
  );

  // x read bus decodes the whole space
  always_comb begin
    xr_word = WORD_ZERO;
    if (in_sfr(xr_ea)) begin
      xr_word = sfr_hit_i ? sfr_rdata_i : WORD_ZERO;
    end else if (in_gen(xr_ea)) begin
      xr_word = gen_mem_r[gen_idx(xr_ea)];
    end else if (in_dma(xr_ea)) begin
      xr_word = dx_word;
    end
  end

  // y path only sees y ram
  always_comb begin
    yr_word = WORD_ZERO;
    if (in_gen(yr_ea) && (yr_ea >= Y_LO)) begin
      yr_word = gen_mem_r[gen_idx(yr_ea)];
    end else if (in_dma(yr_ea)) begin
      yr_word = dy_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xr_rdata_o <= WORD_ZERO;
      xr_valid_o <= 1'b0;
    end else begin
      xr_valid_o <= xr_req_i;
      if (xr_req_i) begin
        xr_rdata_o <= lane_sel(xr_word, xr_byte_i, xr_ea[0]);
      end
    end
  end

  // y read runs beside x read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      yr_rdata_o <= WORD_ZERO;
      yr_valid_o <= 1'b0;
    end else begin
      yr_valid_o <= yr_req_i;
      if (yr_req_i) begin
        yr_rdata_o <= yr_word;
      end
    end
  end

  // combined error flag plus a write-only flag, both one cycle after the access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_err_o <= 1'b0;
      addr_err_wr_o <= 1'b0;
    end else begin
      addr_err_o <= xr_mis || yr_mis || xw_mis;
      addr_err_wr_o <= xw_mis;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wop_res_o <= WORD_ZERO;
      wop_done_o <= 1'b0;
    end else begin
      wop_done_o <= (wop_i != WOP_NONE);
      unique case (wop_i)
        WOP_NONE: wop_res_o <= wop_res_o;
        WOP_WORD: wop_res_o <= wop_data_i;
        WOP_BYTE: wop_res_o <= {wop_reg_i[15:8], wop_data_i[7:0]};
        WOP_SEXT: wop_res_o <= {{8{wop_reg_i[7]}}, wop_reg_i[7:0]};
        WOP_UEXT: wop_res_o <= {8'h00, wop_reg_i[7:0]};
        default: wop_res_o <= wop_res_o;
      endcase
    end
  end
endmodule // dsau_top
`default_nettype wire

/* File: dsau_pkg.sv */
// shared constants and types for the data space access unit
package dsau_pkg;
  localparam int DW = 16;
  localparam int AW = 16;
  localparam int NEAR_W = 13;
  localparam int WIN_BIT = 15;
  localparam logic [15:0] SFR_HI = 16'h07FF;
  localparam logic [15:0] NEAR_HI = 16'h1FFF;
  localparam logic [15:0] RAM_LO = 16'h0800;
  localparam logic [15:0] Y_LO = 16'h1800;
  localparam logic [15:0] DMA_LO = 16'h2400;
  localparam logic [15:0] DMA_HI = 16'h27FF;
  localparam int GEN_WORDS = 3584;
  localparam int GEN_IW = 12;
  localparam int DMA_WORDS = 512;
  localparam int DMA_IW = 9;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [1:0] BE_NONE = 2'h0;
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_ALL = 2'h3;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    AM_NEAR = 2'b00,
    AM_DIR16 = 2'b01,
    AM_IND = 2'b10,
    AM_IND_PI = 2'b11
  } dsau_amode_t;

  typedef enum logic [2:0] {
    WOP_NONE = 3'b000,
    WOP_WORD = 3'b001,
    WOP_BYTE = 3'b010,
    WOP_SEXT = 3'b011,
    WOP_UEXT = 3'b100
  } dsau_wop_t;
endpackage

/* File: dsau_dmaram.sv */
// dual ported dma ram with cpu write precedence
`timescale 1ns/1ns
`default_nettype none
module dsau_dmaram (
  input wire logic clk_i,
  input wire logic rst_i,
  // cpu side
  input wire logic cpu_we_i,
  input wire logic [1:0] cpu_be_i,
  input wire logic [dsau_pkg::DMA_IW-1:0] cpu_widx_i,
  input wire logic [15:0] cpu_wdata_i,
  input wire logic [dsau_pkg::DMA_IW-1:0] xr_idx_i,
  input wire logic [dsau_pkg::DMA_IW-1:0] yr_idx_i,
  output logic [15:0] xr_word_o,
  output logic [15:0] yr_word_o,
  // dma side
  input wire logic dma_req_i,
  input wire logic dma_we_i,
  input wire logic [dsau_pkg::DMA_IW-1:0] dma_idx_i,
  input wire logic [15:0] dma_wdata_i,
  output logic [15:0] dma_rdata_o,
  output logic dma_valid_o,
  output logic dma_lost_o
);
  import dsau_pkg::*;

  logic [15:0] mem_r [DMA_WORDS];
  logic dma_wr;
  logic clash;

  assign dma_wr = dma_req_i && dma_we_i;
  assign clash = dma_wr && cpu_we_i && (cpu_widx_i == dma_idx_i);
  assign xr_word_o = mem_r[xr_idx_i];
  assign yr_word_o = mem_r[yr_idx_i];

  always_ff @(posedge clk_i) begin
    if (dma_wr) begin
      mem_r[dma_idx_i] <= dma_wdata_i;
    end
    if (cpu_we_i) begin
      if (cpu_be_i[0]) begin
        mem_r[cpu_widx_i][7:0] <= cpu_wdata_i[7:0];
      end
      if (cpu_be_i[1]) begin
        mem_r[cpu_widx_i][15:8] <= cpu_wdata_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_rdata_o <= WORD_ZERO;
      dma_valid_o <= 1'b0;
      dma_lost_o <= 1'b0;
    end else begin
      dma_valid_o <= dma_req_i;
      dma_lost_o <= clash;
      if (dma_req_i && !dma_we_i) begin
        dma_rdata_o <= mem_r[dma_idx_i];
      end
    end
  end
endmodule // dsau_dmaram
`default_nettype wire

/* File: dsau_top_props.sv */
// assertions on the data space access unit ports
`timescale 1ns/1ns
`default_nettype none
module dsau_top_props
  import dsau_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic xr_req_i,
  input wire logic xr_byte_i,
  input wire dsau_pkg::dsau_amode_t xr_mode_i,
  input wire logic [15:0] xr_ptr_i,
  input wire logic [15:0] xr_ptr_nxt_o,
  input wire logic xr_valid_o,
  input wire logic xmod_en_i,
  input wire logic yr_req_i,
  input wire logic xw_req_i,
  input wire logic xw_byte_i,
  input wire dsau_pkg::dsau_amode_t xw_mode_i,
  input wire logic [15:0] xw_lit_i,
  input wire logic [15:0] xw_ptr_i,
  input wire logic [15:0] xw_wdata_i,
  input wire logic [1:0] sfr_wbe_o,
  input wire logic [15:0] sfr_wdata_o,
  input wire dsau_pkg::dsau_wop_t wop_i,
  input wire logic [15:0] wop_reg_i,
  input wire logic [15:0] wop_data_i,
  input wire logic [15:0] wop_res_o,
  input wire logic wop_done_o,
  input wire logic addr_err_o,
  input wire logic addr_err_wr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_xr_lat;
    xr_req_i |=> xr_valid_o;
  endproperty
  a_xr_lat: assert property (p_xr_lat)
    else $error("x read not answered");
  property p_odd_rd;
    xr_req_i && !xr_byte_i && xr_mode_i == AM_IND && xr_ptr_i[0] && !xw_req_i
      |=> addr_err_o && !addr_err_wr_o;
  endproperty
  a_odd_rd: assert property (p_odd_rd)
    else $error("odd word read not flagged");
  property p_odd_wr;
    xw_req_i && !xw_byte_i && xw_mode_i == AM_IND && xw_ptr_i[0]
      |=> addr_err_o && addr_err_wr_o && sfr_wbe_o == BE_NONE;
  endproperty
  a_odd_wr: assert property (p_odd_wr)
    else $error("odd word write not flagged");
  property p_err_src;
    addr_err_o |-> $past(xr_req_i) || $past(yr_req_i) || $past(xw_req_i);
  endproperty
  a_err_src: assert property (p_err_src)
    else $error("address error without access");
  property p_postinc;
    xr_mode_i == AM_IND_PI && !xmod_en_i
      |-> xr_ptr_nxt_o == xr_ptr_i + (xr_byte_i ? STEP_BYTE : STEP_WORD);
  endproperty
  a_postinc: assert property (p_postinc)
    else $error("post increment step wrong");
  property p_wop_byte;
    wop_i == WOP_BYTE |=> wop_done_o &&
      wop_res_o == {$past(wop_reg_i[15:8]), $past(wop_data_i[7:0])};
  endproperty
  a_wop_byte: assert property (p_wop_byte)
    else $error("byte load touched high byte");
  property p_wop_se;
    wop_i == WOP_SEXT |=>
      wop_res_o == {{8{$past(wop_reg_i[7])}}, $past(wop_reg_i[7:0])};
  endproperty
  a_wop_se: assert property (p_wop_se)
    else $error("sign extend wrong");
  property p_sfr_lane;
    xw_req_i && xw_byte_i && xw_mode_i == AM_DIR16 && xw_lit_i <= SFR_HI
      && xw_lit_i[0] |=> sfr_wbe_o == BE_HI &&
      sfr_wdata_o[15:8] == $past(xw_wdata_i[7:0]);
  endproperty
  a_sfr_lane: assert property (p_sfr_lane)
    else $error("odd byte write lane wrong");
endmodule // dsau_top_props
bind dsau_top dsau_top_props dsau_top_props_inst (.*);
`default_nettype wire

/* File: dsau_sfr_model.sv */
// peripheral register block answering the sfr bus
`timescale 1ns/1ns
`default_nettype none
module dsau_sfr_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // read side
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  output logic hit_o,
  output logic [15:0] rdata_o,
  // write side
  input wire logic [15:0] waddr_i,
  input wire logic [1:0] wbe_i,
  input wire logic [15:0] wdata_i
);
  logic [15:0] regs_r [16];
  assign hit_o = rd_i && addr_i[15:5] == 11'h001;
  // unclaimed reads show noise so a missing zero fill is seen
  assign rdata_o = hit_o ? regs_r[addr_i[4:1]] : ~addr_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        regs_r[i] <= 16'h0000;
      end
    end else if (waddr_i[15:5] == 11'h001) begin
      if (wbe_i[0]) begin
        regs_r[waddr_i[4:1]][7:0] <= wdata_i[7:0];
      end
      if (wbe_i[1]) begin
        regs_r[waddr_i[4:1]][15:8] <= wdata_i[15:8];
      end
    end
  end
endmodule // dsau_sfr_model
`default_nettype wire

/* File: data_space_access_unit_tb_top.sv */
// self-checking bench for the data space access unit
`timescale 1ns/1ns
`default_nettype none
module data_space_access_unit_tb_top;
  import dsau_pkg::*;
  logic clk_i, rst_i, xr_req_i, xr_byte_i, yr_req_i, yr_postinc_i;
  logic xmod_en_i, ymod_en_i, xw_req_i, xw_byte_i, xw_bitrev_en_i;
  logic dma_req_i, dma_we_i, sfr_hit_i, xr_valid_o, yr_valid_o, sfr_rd_o;
  logic dma_valid_o, dma_lost_o, wop_done_o, addr_err_o, addr_err_wr_o;
  dsau_amode_t xr_mode_i, xw_mode_i;
  dsau_wop_t wop_i;
  logic [15:0] xr_lit_i, xr_ptr_i, yr_ptr_i, xmod_start_i, xmod_end_i;
  logic [15:0] ymod_start_i, ymod_end_i, xw_lit_i, xw_ptr_i, xw_wdata_i;
  logic [15:0] xw_brmod_i, sfr_rdata_i, dma_wdata_i, wop_reg_i, wop_data_i;
  logic [15:0] xr_ptr_nxt_o, xr_rdata_o, yr_ptr_nxt_o, yr_rdata_o;
  logic [15:0] xw_ptr_nxt_o, sfr_addr_o, sfr_waddr_o, sfr_wdata_o;
  logic [15:0] dma_rdata_o, wop_res_o, a;
  logic [1:0] sfr_wbe_o;
  logic [DMA_IW-1:0] dma_idx_i, k;
  logic [15:0] mem [logic [15:0]];
  logic [31:0] seed, r;
  int err_count, total_checks;
  dsau_top dsau_top_inst (.*);
  dsau_sfr_model dsau_sfr_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(sfr_addr_o), .rd_i(sfr_rd_o), .hit_o(sfr_hit_i),
    .rdata_o(sfr_rdata_i), .waddr_i(sfr_waddr_o), .wbe_i(sfr_wbe_o),
    .wdata_i(sfr_wdata_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // gaps, unclaimed registers and the upper half all read as zero
  function automatic logic [15:0] ex(input logic [15:0] x);
    logic [15:0] w;
    w = {x[15:1], 1'b0};
    if (w[15] || w > DMA_HI || !mem.exists(w)) return WORD_ZERO;
    if (w < RAM_LO && w[15:5] != 11'h001) return WORD_ZERO;
    return mem[w];
  endfunction
  task automatic chk(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // reversed-carry sum: carries run from the top bit downwards
  function automatic logic [15:0] rcadd(input logic [15:0] p, m);
    logic [15:0] s;
    logic c;
    c = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      {c, s[i]} = p[i] + m[i] + c;
    end
    return s;
  endfunction
  task automatic report_and_stop();
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic xread(input logic [15:0] x, input logic b, dsau_amode_t m);
    logic [15:0] w;
    @(negedge clk_i);
    xr_req_i = 1'b1;
    xr_byte_i = b;
    xr_mode_i = m;
    xr_lit_i = (m == AM_NEAR) ? (x | 16'hE000) : x;
    xr_ptr_i = x;
    @(negedge clk_i);
    xr_req_i = 1'b0;
    w = ex(x);
    if (b) w = {8'h00, x[0] ? w[15:8] : w[7:0]};
    chk("xr_rdata", xr_rdata_o, w);
    chk("xr_valid", {15'h0, xr_valid_o}, 16'h0001);
    chk("rd_err", {15'h0, addr_err_o}, {15'h0, !b && x[0]});
  endtask
  task automatic xwrite(input logic [15:0] x, input logic b,
                        input logic [15:0] d,
                        input dsau_amode_t m);
    logic [15:0] w;
    @(negedge clk_i);
    xw_req_i = 1'b1;
    xw_byte_i = b;
    xw_mode_i = m;
    xw_lit_i = x;
    xw_ptr_i = x;
    xw_wdata_i = d;
    @(negedge clk_i);
    xw_req_i = 1'b0;
    chk("wr_err", {15'h0, addr_err_wr_o}, {15'h0, !b && x[0]});
    w = {x[15:1], 1'b0};
    if (!mem.exists(w)) mem[w] = WORD_ZERO;
    if (b && x[0]) mem[w][15:8] = d[7:0];
    else if (b) mem[w][7:0] = d[7:0];
    else if (!x[0]) mem[w] = d;
  endtask
  task automatic yread(input logic [15:0] x);
    @(negedge clk_i);
    yr_req_i = 1'b1;
    yr_ptr_i = x;
    @(negedge clk_i);
    yr_req_i = 1'b0;
    chk("yr_rdata", yr_rdata_o, x >= Y_LO ? ex(x) : WORD_ZERO);
    chk("yr_valid", {15'h0, yr_valid_o}, 16'h0001);
    chk("yr_err", {15'h0, addr_err_o}, {15'h0, x[0]});
  endtask
  task automatic dma_op(input logic we, input logic [DMA_IW-1:0] i,
                        input logic [15:0] d);
    @(negedge clk_i);
    dma_req_i = 1'b1;
    dma_we_i = we;
    dma_idx_i = i;
    dma_wdata_i = d;
    @(negedge clk_i);
    dma_req_i = 1'b0;
    chk("dma_valid", {15'h0, dma_valid_o}, 16'h0001);
  endtask
  task automatic wop(input dsau_wop_t o, input logic [15:0] g, d);
    logic [15:0] e;
    @(negedge clk_i);
    wop_i = o;
    wop_reg_i = g;
    wop_data_i = d;
    @(negedge clk_i);
    wop_i = WOP_NONE;
    case (o)
      WOP_BYTE: e = {g[15:8], d[7:0]};
      WOP_SEXT: e = {{8{g[7]}}, g[7:0]};
      WOP_UEXT: e = {8'h00, g[7:0]};
      default: e = d;
    endcase
    chk("wop_res", wop_res_o, e);
    chk("wop_done", {15'h0, wop_done_o}, 16'h0001);
  endtask
  // window ends just past p, so a word step wraps and a byte step does not
  task automatic ptrchk(input logic [15:0] p, m, input logic b, me);
    logic [15:0] e;
    @(negedge clk_i);
    xr_mode_i = AM_IND_PI;
    xw_mode_i = AM_IND_PI;
    xr_ptr_i = p;
    xw_ptr_i = p;
    xr_byte_i = b;
    xw_byte_i = b;
    yr_postinc_i = 1'b1;
    yr_ptr_i = p;
    {xmod_en_i, ymod_en_i} = {me, me};
    {xmod_start_i, ymod_start_i} = {2{p & 16'hFFF0}};
    {xmod_end_i, ymod_end_i} = {2{p | 16'h0001}};
    #10;
    e = (me && !b) ? (p & 16'hFFF0) : p + (b ? STEP_BYTE : STEP_WORD);
    chk("xr_ptr", xr_ptr_nxt_o, e);
    chk("xw_ptr", xw_ptr_nxt_o, e);
    chk("yr_ptr", yr_ptr_nxt_o, me ? (p & 16'hFFF0) : p + STEP_WORD);
    // bit-reversed stepping applies to word writes only
    xw_byte_i = 1'b0;
    xw_bitrev_en_i = 1'b1;
    xw_brmod_i = m;
    #10;
    chk("xw_brev", xw_ptr_nxt_o, rcadd(p, m));
    {xmod_en_i, ymod_en_i, yr_postinc_i, xw_bitrev_en_i} = 4'h0;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end
  initial begin
    seed = 32'h5753;
    {xr_req_i, xr_byte_i, yr_req_i, yr_postinc_i, xmod_en_i} = 5'h00;
    {ymod_en_i, xw_req_i, xw_byte_i, xw_bitrev_en_i, dma_req_i} = 5'h00;
    {xr_lit_i, xr_ptr_i, yr_ptr_i, xmod_start_i, xmod_end_i} = 80'h0;
    {ymod_start_i, ymod_end_i, xw_lit_i, xw_ptr_i, xw_wdata_i} = 80'h0;
    {xw_brmod_i, dma_wdata_i, wop_reg_i, wop_data_i} = 64'h0;
    {dma_we_i, dma_idx_i} = 10'h000;
    xr_mode_i = AM_NEAR;
    xw_mode_i = AM_NEAR;
    wop_i = WOP_NONE;
    rst_i = 1'b1;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      a = (i % 4 == 0) ? {11'h001, r[4:1], 1'b0} : RAM_LO + {r[12:1], 1'b0};
      xwrite(a, 1'b0, r[15:0], i[0] ? AM_DIR16 : AM_IND);
      xwrite({a[15:1], r[0]}, 1'b1, r[31:16], AM_DIR16);
      xwrite(a | 16'h0001, 1'b0, ~r[15:0], AM_IND);
      xread(a, 1'b0, AM_IND);
      xread(a, 1'b1, AM_DIR16);
      xread(a | 16'h0001, 1'b1, AM_IND_PI);
      xread(a | 16'h0001, 1'b0, AM_IND);
      if (a <= NEAR_HI) xread(a, 1'b0, AM_NEAR);
      yread(a);
      yread(a | 16'h0001);
      wop(dsau_wop_t'(3'(i % 4 + 1)), r[15:0], r[31:16]);
      ptrchk(a, r[31:16], r[2], r[3]);
    end
    for (int i = 0; i < 4; i++) begin
      xread(i[1] ? {i[0], 15'h2A00} : {i[0], 15'h0100}, 1'b0,
            AM_DIR16);
    end
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      k = {r[9:2], 1'b0};
      a = DMA_LO + {6'h00, k, 1'b0};
      fork
        xwrite(a, 1'b0, r[15:0], AM_DIR16);
        dma_op(1'b1, k, ~r[15:0]);
      join
      chk("dma_lost", {15'h0, dma_lost_o}, 16'h0001);
      dma_op(1'b0, k, r[31:16]);
      chk("dma_rdata", dma_rdata_o, r[15:0]);
      dma_op(1'b1, k + 9'h001, r[31:16]);
      chk("dma_lost", {15'h0, dma_lost_o}, 16'h0000);
      mem[a + 16'h0002] = r[31:16];
      xread(a + 16'h0002, 1'b0, AM_IND);
    end
    report_and_stop();
  end
endmodule // data_space_access_unit_tb_top
`default_nettype wire
